// [rtl/ies_regs.vh]
// Purpose: constants for the instruction execute subset
// Assumes: included by the design files by bare name
// Notes: opcodes are a local code, not the real instruction encoding
`ifndef IES_REGS_VH
`define IES_REGS_VH

// operation codes presented on op_code
`define IES_OP_NOP 5'h00
`define IES_OP_CLRM 5'h01
`define IES_OP_SETM 5'h02
`define IES_OP_CLRWDT 5'h03
`define IES_OP_WDT1 5'h04
`define IES_OP_WDT2 5'h05
`define IES_OP_SWAP 5'h06
`define IES_OP_SWAPW 5'h07
`define IES_OP_HALT 5'h08
`define IES_OP_ADC 5'h09
`define IES_OP_ADCMEM 5'h0a
`define IES_OP_ADD 5'h0b
`define IES_OP_ADDI 5'h0c
`define IES_OP_ADDMEM 5'h0d
`define IES_OP_AND 5'h0e
`define IES_OP_ANDI 5'h0f
`define IES_OP_ANDMEM 5'h10
`define IES_OP_TRDC 5'h11
`define IES_OP_TRDL 5'h12
`define IES_OP_SKIP 5'h13

// data memory address of the program counter low byte
`define IES_PCLO_ADDR 8'h06
// page number of the last program memory page
`define IES_LAST_PAGE 4'hf
// reset values
`define IES_RST_WORK 8'h00
`define IES_RST_THB 7'h00
// machine cycles of short and long instructions
`define IES_CYC_SHORT 2'h1
`define IES_CYC_LONG 2'h2

`endif

// [rtl/ies_alu.v]
// Purpose: 8-bit adder and and-unit with status flags
// Assumes: purely combinational
// Notes: overflow is carry into bit 7 xor carry out of bit 7
`timescale 1ns/1ps
module ies_alu (
    input wire [7:0] a,
    input wire [7:0] b,
    input wire cin,
    input wire sel_and,
    output reg [7:0] res,
    output reg c_out,
    output reg hc_out,
    output reg sv_out,
    output reg z_out
);
    reg [4:0] low;
    reg [7:0] sum7;

    // add path keeps nibble and bit-7 carries for half and signed flags
    always @* begin
        low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        sum7 = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, cin};
        {c_out, res} = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        hc_out = low[4];
        sv_out = sum7[7] ^ c_out;
        if (sel_and) begin
            res = a & b;
            c_out = 1'b0;
            hc_out = 1'b0;
            sv_out = 1'b0;
        end
        z_out = (res == 8'h00);
    end
endmodule // ies_alu

// [rtl/ies_exec.v]
// Purpose: executes table reads, misc ops, add/adc and and families
// Assumes: data byte [m] is valid on mem_rdata with op_start;
//          program memory answers prog_data within the cycle in which prog_rd stands
// Notes: one op at a time; op_start is only honoured while op_ready
//
// Behaviour
// - current-page table read: high part to table high byte, low to [m], 2 cycles.
// - last-page table read: same transfer from last page, 2 cycles, flags kept.
// - nibble swap of [m], result to [m] or working register, flags kept.
// - power-down op takes 1 cycle, enters power-down, updates timeout/power flags.
// - both pre-clear ops back to back clear timeout and power flags; else kept.
// - conditional skip takes two cycles when skipping, one otherwise.
// - any write of the program counter low byte takes 2 cycles.
// - add-with-carry sums working, [m] and carry; updates all four flags.
// - memory-destination add and add-with-carry write the sum into [m].
// - plain add from memory sums working and [m] without carry, four flags.
// - immediate add sums working and immediate into working, four flags.
// - and with memory is bitwise, changes only zero flag.
// - immediate and into working register, only zero flag changes.
// - memory-destination and writes result into [m], only zero flag.
// - watchdog clear resets counter and clears timeout and power flags.
// - clear-memory forces [m] to zero, no flag change.
`timescale 1ns/1ps
`include "ies_regs.vh"
module ies_exec #(
    parameter PC_W = 12,
    parameter PW_W = 15
) (
    input wire mclk,
    input wire sys_rst,
    input wire op_start,
    input wire [4:0] op_code,
    input wire [7:0] op_addr,
    input wire [7:0] op_imm,
    input wire [7:0] mem_rdata,
    input wire skip_cond,
    input wire [PC_W-1:0] pc,
    input wire [7:0] table_ptr,
    input wire [PW_W-1:0] prog_data,
    input wire wdt_timeout,
    input wire wake,
    output reg op_ready,
    output reg op_done,
    output reg [1:0] op_cycles,
    output reg skip_next,
    output reg mem_we,
    output reg [7:0] mem_waddr,
    output reg [7:0] mem_wdata,
    output reg prog_rd,
    output reg [PC_W-1:0] prog_addr,
    output reg [7:0] working_register,
    output reg [PW_W-9:0] table_high_byte_reg,
    output reg carry_flag,
    output reg auxiliary_carry_flag,
    output reg zero_flag,
    output reg twos_complement_excess_flag,
    output reg watchdog_timeout_flag,
    output reg power_down_flag,
    output reg watchdog_clear,
    output reg power_down
);
    localparam ST_IDLE = 2'h0;
    localparam ST_TBL = 2'h1;
    localparam ST_LONG = 2'h2;
    localparam PRE_NONE = 2'h0;
    localparam PRE_FIRST = 2'h1;
    localparam PRE_SECOND = 2'h2;

    reg [1:0] state;
    reg [1:0] pre_seen;
    reg [7:0] alu_b;
    reg alu_cin;
    reg alu_and;
    wire [7:0] alu_res;
    wire alu_c;
    wire alu_hc;
    wire alu_sv;
    wire alu_z;
    wire take;
    wire [7:0] swapped;
    wire pclo_target;

    assign take = op_start & op_ready;
    assign swapped = {mem_rdata[3:0], mem_rdata[7:4]};
    assign pclo_target = (op_addr == `IES_PCLO_ADDR);

    ////////////////////////////////////////////////////////////////////
    // operand selection for the arithmetic unit
    always @* begin
        alu_b = mem_rdata;
        alu_cin = 1'b0; // plain add ignores carry
        alu_and = 1'b0;
        case (op_code)
            `IES_OP_ADC, `IES_OP_ADCMEM: alu_cin = carry_flag;
            `IES_OP_ADDI: alu_b = op_imm;
            `IES_OP_AND, `IES_OP_ANDMEM: alu_and = 1'b1;
            `IES_OP_ANDI: begin
                alu_b = op_imm;
                alu_and = 1'b1;
            end
            default: alu_cin = 1'b0;
        endcase
    end

    ies_alu u_alu (
        .a(working_register),
        .b(alu_b),
        .cin(alu_cin),
        .sel_and(alu_and),
        .res(alu_res),
        .c_out(alu_c),
        .hc_out(alu_hc),
        .sv_out(alu_sv),
        .z_out(alu_z)
    );

    ////////////////////////////////////////////////////////////////////
    // sequencing, data path and flags
    always @(posedge mclk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            pre_seen <= PRE_NONE;
            op_ready <= 1'b1;
            op_done <= 1'b0;
            op_cycles <= 2'h0;
            skip_next <= 1'b0;
            mem_we <= 1'b0;
            mem_waddr <= 8'h00;
            mem_wdata <= 8'h00;
            prog_rd <= 1'b0;
            prog_addr <= {PC_W{1'b0}};
            working_register <= `IES_RST_WORK;
            table_high_byte_reg <= `IES_RST_THB;
            carry_flag <= 1'b0;
            auxiliary_carry_flag <= 1'b0;
            zero_flag <= 1'b0;
            twos_complement_excess_flag <= 1'b0;
            watchdog_timeout_flag <= 1'b0;
            power_down_flag <= 1'b0;
            watchdog_clear <= 1'b0;
            power_down <= 1'b0;
        end else begin
            // pulses default low each cycle
            op_done <= 1'b0;
            mem_we <= 1'b0;
            prog_rd <= 1'b0;
            watchdog_clear <= 1'b0;
            skip_next <= 1'b0;
            if (wake) begin
                power_down <= 1'b0;
            end
            case (state)
                ST_IDLE: begin
                    if (take) begin
                        op_cycles <= `IES_CYC_SHORT;
                        op_done <= 1'b1;
                        mem_waddr <= op_addr;
                        // pre-clear pairing breaks on any other op
                        pre_seen <= PRE_NONE;
                        case (op_code)
                            `IES_OP_CLRM: begin
                                mem_we <= 1'b1;
                                mem_wdata <= 8'h00;
                            end
                            `IES_OP_SETM: begin
                                mem_we <= 1'b1;
                                mem_wdata <= 8'hff;
                            end
                            `IES_OP_SWAP: begin
                                mem_we <= 1'b1;
                                mem_wdata <= swapped;
                            end
                            `IES_OP_SWAPW: working_register <= swapped;
                            `IES_OP_CLRWDT: begin
                                watchdog_clear <= 1'b1;
                                watchdog_timeout_flag <= wdt_timeout;
                                power_down_flag <= 1'b0;
                            end
                            `IES_OP_WDT1, `IES_OP_WDT2: begin
                                if ((op_code == `IES_OP_WDT1 &&
                                     pre_seen == PRE_SECOND) ||
                                    (op_code == `IES_OP_WDT2 &&
                                     pre_seen == PRE_FIRST)) begin
                                    watchdog_clear <= 1'b1;
                                    watchdog_timeout_flag <= wdt_timeout;
                                    power_down_flag <= 1'b0;
                                end else begin
                                    pre_seen <= (op_code == `IES_OP_WDT1) ?
                                        PRE_FIRST : PRE_SECOND;
                                end
                            end
                            `IES_OP_HALT: begin
                                // one cycle, then sleep until wake
                                power_down <= 1'b1;
                                power_down_flag <= 1'b1;
                                watchdog_timeout_flag <= wdt_timeout;
                                watchdog_clear <= 1'b1;
                            end
                            `IES_OP_ADC, `IES_OP_ADD, `IES_OP_ADDI: begin
                                working_register <= alu_res;
                                carry_flag <= alu_c;
                                auxiliary_carry_flag <= alu_hc;
                                zero_flag <= alu_z;
                                twos_complement_excess_flag <= alu_sv;
                            end
                            `IES_OP_ADCMEM, `IES_OP_ADDMEM: begin
                                mem_we <= 1'b1;
                                mem_wdata <= alu_res;
                                carry_flag <= alu_c;
                                auxiliary_carry_flag <= alu_hc;
                                zero_flag <= alu_z;
                                twos_complement_excess_flag <= alu_sv;
                            end
                            `IES_OP_AND, `IES_OP_ANDI: begin
                                working_register <= alu_res;
                                zero_flag <= alu_z;
                            end
                            `IES_OP_ANDMEM: begin
                                mem_we <= 1'b1;
                                mem_wdata <= alu_res;
                                zero_flag <= alu_z;
                            end
                            `IES_OP_TRDC, `IES_OP_TRDL: begin
                                // word arrives next cycle
                                op_done <= 1'b0;
                                op_ready <= 1'b0;
                                prog_rd <= 1'b1;
                                prog_addr <= (op_code == `IES_OP_TRDC) ?
                                    {pc[PC_W-1:8], table_ptr} :
                                    {`IES_LAST_PAGE, table_ptr};
                                state <= ST_TBL;
                            end
                            `IES_OP_SKIP: begin
                                if (skip_cond) begin
                                    op_done <= 1'b0;
                                    op_ready <= 1'b0;
                                    state <= ST_LONG;
                                end
                            end
                            default: op_cycles <= `IES_CYC_SHORT;
                        endcase
                        // a write landing on the pc low byte costs a cycle
                        if (pclo_target && (op_code == `IES_OP_CLRM ||
                            op_code == `IES_OP_SETM ||
                            op_code == `IES_OP_SWAP ||
                            op_code == `IES_OP_ADCMEM ||
                            op_code == `IES_OP_ADDMEM ||
                            op_code == `IES_OP_ANDMEM)) begin
                            op_done <= 1'b0;
                            op_ready <= 1'b0;
                            state <= ST_LONG;
                        end
                    end
                end
                ST_TBL: begin
                    // capture word; flags untouched
                    table_high_byte_reg <= prog_data[PW_W-1:8];
                    mem_we <= 1'b1;
                    mem_wdata <= prog_data[7:0];
                    op_cycles <= `IES_CYC_LONG;
                    op_done <= 1'b1;
                    op_ready <= 1'b1;
                    state <= ST_IDLE;
                end
                ST_LONG: begin
                    // second cycle for skip and pc writes
                    op_cycles <= `IES_CYC_LONG;
                    op_done <= 1'b1;
                    op_ready <= 1'b1;
                    skip_next <= (op_cycles == `IES_CYC_SHORT) & ~mem_we;
                    state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
            // a timeout event wins over any clear in the same cycle
            if (wdt_timeout) begin
                watchdog_timeout_flag <= 1'b1;
            end
        end
    end
endmodule // ies_exec

// [testbench/ies_exec_asserts.sv]
// Purpose: port checker for ies_exec
// Assumes: bound onto every ies_exec
// Notes: long ops drop op_ready for exactly one cycle
`timescale 1ns/1ps
`include "ies_regs.vh"
module ies_exec_asserts #(
    parameter PC_W = 12,
    parameter PW_W = 15
) (
    input wire mclk,
    input wire sys_rst,
    input wire op_start,
    input wire op_ready,
    input wire [4:0] op_code,
    input wire [7:0] op_addr,
    input wire [7:0] mem_rdata,
    input wire [7:0] table_ptr,
    input wire skip_cond,
    input wire wdt_timeout,
    input wire op_done,
    input wire [1:0] op_cycles,
    input wire mem_we,
    input wire [7:0] mem_wdata,
    input wire prog_rd,
    input wire [PC_W-1:0] prog_addr,
    input wire carry_flag,
    input wire watchdog_timeout_flag,
    input wire power_down_flag,
    input wire power_down
);
    reg [7:0] last_rd;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // byte seen at the taking edge, for the swap check
    always @(posedge mclk) last_rd <= mem_rdata;
    sequence s_take(logic [4:0] c);
        op_start && op_ready && op_code == c;
    endsequence
    sequence s_long;
        !op_ready ##1 (op_done && op_cycles == 2'h2);
    endsequence
    sequence s_short;
        op_done && op_cycles == 2'h1;
    endsequence
    a_add_short: assert property (s_take(`IES_OP_ADD) |=> s_short)
        else $error("add not done in one cycle");
    a_trdc_long: assert property (s_take(`IES_OP_TRDC)
        |=> prog_rd ##0 s_long)
        else $error("table read timing wrong");
    a_trdl_page: assert property (s_take(`IES_OP_TRDL) |=>
        prog_addr == {`IES_LAST_PAGE, $past(table_ptr)})
        else $error("last page address wrong");
    a_skip_taken: assert property (s_take(`IES_OP_SKIP) ##0 skip_cond
        |=> s_long)
        else $error("taken skip not two cycles");
    a_skip_none: assert property (s_take(`IES_OP_SKIP) ##0 !skip_cond
        |=> s_short)
        else $error("plain skip not one cycle");
    a_pcl_write: assert property (s_take(`IES_OP_CLRM)
        ##0 op_addr == `IES_PCLO_ADDR |=> mem_we ##0 s_long)
        else $error("pc low byte write not two cycles");
    a_clr_zero: assert property (s_take(`IES_OP_CLRM)
        |=> mem_we && mem_wdata == 8'h00)
        else $error("clear byte not zero");
    a_swap_nib: assert property (s_take(`IES_OP_SWAP) |=>
        mem_we && mem_wdata == {last_rd[3:0], last_rd[7:4]})
        else $error("swap result wrong");
    a_and_carry: assert property (s_take(`IES_OP_AND)
        |=> $stable(carry_flag))
        else $error("and changed carry");
    a_halt_power: assert property (s_take(`IES_OP_HALT) |=>
        op_done && power_down && power_down_flag)
        else $error("power-down not entered");
    // no op may be taken between the halves, or the pair is broken
    a_pair_clear: assert property (s_take(`IES_OP_WDT1)
        ##1 !(op_start && op_ready) ##1 s_take(`IES_OP_WDT2)
        ##0 !wdt_timeout |=> !watchdog_timeout_flag && !power_down_flag)
        else $error("pre-clear pair kept flags");
endmodule // ies_exec_asserts

// [testbench/ies_mem_model.sv]
// Purpose: data and program memory beside ies_exec
// Assumes: program word due within the cycle in which prog_rd stands
// Notes: prog_data toggles when not answering, so stale use shows
`timescale 1ns/1ps
module ies_mem_model (
    input wire mclk,
    input wire [7:0] op_addr,
    input wire mem_we,
    input wire [7:0] mem_waddr,
    input wire [7:0] mem_wdata,
    input wire prog_rd,
    input wire [11:0] prog_addr,
    output wire [7:0] mem_rdata,
    output reg [14:0] prog_data
);
    reg [7:0] dmem [0:255];
    integer i;
    initial begin
        for (i = 0; i < 256; i = i + 1) dmem[i] = i[7:0] ^ 8'h96;
        prog_data = 15'h0000;
    end
    assign mem_rdata = dmem[op_addr];
    // write port lands on the edge after the strobe
    always @(posedge mclk) begin
        if (mem_we) dmem[mem_waddr] <= mem_wdata;
    end
    // word put up mid-cycle while prog_rd stands, so the edge that
    // closes the read cycle samples it settled
    always @(negedge mclk) begin
        if (prog_rd) prog_data <= {prog_addr[11:5] ^ 7'h2b,
            prog_addr[7:0] ^ 8'h5c};
        else prog_data <= ~prog_data;
    end
endmodule // ies_mem_model

// [testbench/testbench.sv]
// Purpose: self-checking bench for ies_exec
// Assumes: memories come from ies_mem_model
// Notes: fixed-seed random ops plus watchdog and sum corners
`timescale 1ns/1ps
`include "ies_regs.vh"
module testbench;
    reg mclk = 1'b0, sys_rst = 1'b1, op_start = 1'b0, skip_cond = 1'b0;
    reg wdt_timeout = 1'b0, wake = 1'b0;
    reg [4:0] op_code = 5'h00, c;
    reg [7:0] op_addr = 8'h00, op_imm = 8'h00, table_ptr = 8'h00, w = 8'h00;
    reg [11:0] pc = 12'h000;
    reg [31:0] r = 32'd80966;
    reg [7:0] ref_mem [0:255];
    reg [6:0] th = 7'h00;
    reg [5:0] fl = 6'h00;
    reg [4:0] last = 5'h00;
    integer err_count = 0, compares = 0, cyc_n = 0, k;
    wire [7:0] mem_rdata, mem_waddr, mem_wdata, working_register;
    wire [14:0] prog_data;
    wire [11:0] prog_addr;
    wire [6:0] table_high_byte_reg;
    wire [1:0] op_cycles;
    wire op_ready, op_done, mem_we, prog_rd, carry_flag, auxiliary_carry_flag;
    wire zero_flag, twos_complement_excess_flag, watchdog_timeout_flag;
    wire power_down_flag, watchdog_clear, power_down, skip_next;
    // memory-destination and working-destination op masks
    localparam [19:0] MDST = 20'h72446;
    localparam [19:0] WDST = 20'h0da80;
    ies_exec dut_u (.mclk(mclk), .sys_rst(sys_rst), .op_start(op_start),
        .op_code(op_code), .op_addr(op_addr), .op_imm(op_imm),
        .mem_rdata(mem_rdata), .skip_cond(skip_cond), .pc(pc),
        .table_ptr(table_ptr), .prog_data(prog_data), .wake(wake),
        .wdt_timeout(wdt_timeout), .op_ready(op_ready), .op_done(op_done),
        .op_cycles(op_cycles), .skip_next(skip_next), .mem_we(mem_we),
        .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .prog_rd(prog_rd),
        .prog_addr(prog_addr), .working_register(working_register),
        .table_high_byte_reg(table_high_byte_reg), .carry_flag(carry_flag),
        .auxiliary_carry_flag(auxiliary_carry_flag), .zero_flag(zero_flag),
        .twos_complement_excess_flag(twos_complement_excess_flag),
        .watchdog_timeout_flag(watchdog_timeout_flag),
        .power_down_flag(power_down_flag),
        .watchdog_clear(watchdog_clear), .power_down(power_down));
    ies_mem_model mem_u (.mclk(mclk), .op_addr(op_addr), .mem_we(mem_we),
        .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .prog_rd(prog_rd),
        .prog_addr(prog_addr), .mem_rdata(mem_rdata), .prog_data(prog_data));
    ////////////////////////////////////////////////////////////////////////
    function [31:0] lfsr(input [31:0] v);
        lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task chk_v(input [15:0] got, input [15:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task end_sim;
        begin
            if (err_count == 0 && compares > 0) $display("Test passed");
            else $display("Test failed");
            $finish;
        end
    endtask
    // one timeout-flag event between ops
    task pulse_to;
        begin
            @(negedge mclk) wdt_timeout = 1'b1;
            @(negedge mclk) wdt_timeout = 1'b0;
            fl[1] = 1'b1;
        end
    endtask
    // one op: drive, wait bounded for done, then compare to the model
    task run(input [4:0] op, input [7:0] a, input [7:0] im);
        integer n;
        reg [7:0] m, b, res;
        reg [8:0] s;
        reg [4:0] h;
        reg [11:0] pa;
        reg ci, lng, pr, wc;
        begin
            r = lfsr(r);
            m = ref_mem[a];
            b = (op == `IES_OP_ADDI || op == `IES_OP_ANDI) ? im : m;
            @(negedge mclk);
            op_start = 1'b1;
            op_code = op;
            op_addr = a;
            op_imm = im;
            skip_cond = r[7];
            pc = r[19:8];
            table_ptr = r[31:24];
            @(negedge mclk) op_start = 1'b0;
            n = 0;
            while (op_done !== 1'b1 && n < 4) begin
                @(negedge mclk);
                n = n + 1;
            end
            ci = (op == `IES_OP_ADC || op == `IES_OP_ADCMEM) & fl[5];
            s = w + b + ci;
            h = w[3:0] + b[3:0] + ci;
            res = w;
            pa = {op == `IES_OP_TRDL ? 4'hf : pc[11:8], table_ptr};
            if (op >= `IES_OP_ADC && op <= `IES_OP_ADDMEM) begin
                res = s[7:0];
                fl[5:2] = {s[8], h[4], res == 8'h00, (w[7] == b[7]) &&
                    (s[7] != w[7])};
            end
            if (op >= `IES_OP_AND && op <= `IES_OP_ANDMEM) begin
                res = w & b;
                fl[3] = res == 8'h00;
            end
            case (op)
                `IES_OP_SWAP, `IES_OP_SWAPW: res = {m[3:0], m[7:4]};
                `IES_OP_CLRM: res = 8'h00;
                `IES_OP_SETM: res = 8'hff;
                `IES_OP_HALT: fl[1:0] = 2'b01;
                `IES_OP_CLRWDT: fl[1:0] = 2'b00;
                `IES_OP_TRDC, `IES_OP_TRDL: begin
                    {th, res} = {pa[11:5] ^ 7'h2b, pa[7:0] ^ 8'h5c};
                    chk_v({4'h0, prog_addr}, {4'h0, pa});
                end
                default: ;
            endcase
            // a pre-clear pair needs the two halves as neighbouring ops
            pr = (op == `IES_OP_WDT1 && last == `IES_OP_WDT2) ||
                (op == `IES_OP_WDT2 && last == `IES_OP_WDT1);
            if (pr) fl[1:0] = 2'b00;
            wc = op == `IES_OP_CLRWDT || op == `IES_OP_HALT || pr;
            lng = op == `IES_OP_TRDC || op == `IES_OP_TRDL ||
                (op == `IES_OP_SKIP && skip_cond) || (MDST[op] && a == 8'h06);
            if (MDST[op]) ref_mem[a] = res;
            if (MDST[op]) chk_v({mem_waddr, mem_wdata}, {a, res});
            if (WDST[op]) w = res;
            chk_v(watchdog_clear, wc);
            chk_v(skip_next, op == `IES_OP_SKIP && skip_cond);
            chk_v({n[1:0], op_cycles}, {lng, lng, !lng});
            chk_v({1'b0, table_high_byte_reg, working_register}, {1'b0, th, w});
            chk_v({carry_flag, auxiliary_carry_flag, zero_flag,
                twos_complement_excess_flag, watchdog_timeout_flag,
                power_down_flag}, fl);
            if (op == `IES_OP_HALT) begin
                chk_v(power_down, 16'h1);
                @(negedge mclk) wake = 1'b1;
                @(negedge mclk) wake = 1'b0;
                chk_v(power_down, 16'h0);
            end
            // a completed pair starts the pairing afresh
            last = pr ? `IES_OP_NOP : op;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    always #2.5 mclk = ~mclk;
    // hang guard well above the expected run length
    always @(posedge mclk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 5000) begin
            err_count = err_count + 1;
            end_sim;
        end
    end
    initial begin
        for (k = 0; k < 256; k = k + 1) ref_mem[k] = k[7:0] ^ 8'h96;
        repeat (2) @(negedge mclk);
        sys_rst = 1'b0;
        run(`IES_OP_HALT, 8'h10, 8'h00);
        pulse_to;
        run(`IES_OP_WDT1, 8'h00, 8'h00);
        run(`IES_OP_NOP, 8'h00, 8'h00);
        run(`IES_OP_WDT2, 8'h00, 8'h00);
        run(`IES_OP_WDT2, 8'h00, 8'h00);
        run(`IES_OP_WDT1, 8'h00, 8'h00);
        pulse_to;
        run(`IES_OP_NOP, 8'h00, 8'h00);
        run(`IES_OP_WDT1, 8'h00, 8'h00);
        run(`IES_OP_WDT2, 8'h00, 8'h00);
        // zero, signed overflow and carry out at the byte boundary
        run(`IES_OP_SETM, 8'h20, 8'h00);
        run(`IES_OP_ANDI, 8'h00, 8'h00);
        run(`IES_OP_ADDI, 8'h00, 8'h7f);
        run(`IES_OP_ADDI, 8'h00, 8'h01);
        run(`IES_OP_ADD, 8'h20, 8'h00);
        run(`IES_OP_ADCMEM, 8'h06, 8'h00);
        for (k = 0; k < 300; k = k + 1) begin
            r = lfsr(r);
            c = r[4:0] % 5'd20;
            if (c == `IES_OP_WDT1 || c == `IES_OP_WDT2) c = `IES_OP_CLRWDT;
            run(c, r[27] ? 8'h06 : r[31:24], r[15:8]);
        end
        end_sim;
    end
endmodule // testbench
bind ies_exec ies_exec_asserts #(.PC_W(PC_W), .PW_W(PW_W)) chk_u (
    .mclk(mclk), .sys_rst(sys_rst), .op_start(op_start),
    .op_ready(op_ready), .op_code(op_code), .op_addr(op_addr),
    .mem_rdata(mem_rdata), .table_ptr(table_ptr), .skip_cond(skip_cond),
    .wdt_timeout(wdt_timeout), .op_done(op_done), .op_cycles(op_cycles),
    .mem_we(mem_we), .mem_wdata(mem_wdata), .prog_rd(prog_rd),
    .prog_addr(prog_addr), .carry_flag(carry_flag),
    .watchdog_timeout_flag(watchdog_timeout_flag),
    .power_down_flag(power_down_flag), .power_down(power_down));
